/* File: design/mlx_exec.sv */
// Decode and execute of byte transfers between registers and memory
// ==========================================================
// Notes on behaviour
// - Move one byte memory to register or back; source untouched.
// - Pair forms: even pair number means program memory, odd means data.
// - Memory load, store and decrement leave all status flags alone.
// - C3 loads, D3 stores through a pair pointer; 2 bytes, 10 cycles.
// - E7/F7 add third-byte short offset to pair; 3 bytes, 12 cycles.
// - A7/B7 add two-byte offset, low first, to pair; 4 bytes, 14 cycles.
// - Long indexed forms never use pair zero/one as index.
// - A7/B7 pair 0000 is direct program address, 0001 direct data.
// - Program memory stores only on writable variants, never on ROM.
// - Load-decrement loads byte first, then decrements the pair.
// - Load-decrement uses program memory for even pair, data for odd.
`timescale 1ns/1ns
`include "mlx_params.svh"

module mlx_exec
#(
	parameter bit PROG_WRITABLE = 1'b1
)
(
	input  wire logic                clk_i,
	input  wire logic                srst_i,
	input  wire logic                start_i,
	input  wire logic [7:0]          opc_i,
	input  wire logic [7:0]          byte2_i,
	input  wire logic [7:0]          byte3_i,
	input  wire logic [7:0]          byte4_i,
	output logic                     ready_o,
	output logic                     done_o,
	output logic                     illegal_o,
	output logic                     store_blocked_o,
	output logic                     flags_we_o,
	input  wire logic                core_we_i,
	input  wire logic [3:0]          core_addr_i,
	input  wire logic [7:0]          core_wdata_i,
	output logic [7:0]               core_rdata_o,
	output logic                     mem_req_o,
	output logic                     mem_we_o,
	output mlx_pkg::mlx_space_e      mem_space_o,
	output logic [15:0]              mem_addr_o,
	output logic [7:0]               mem_wdata_o,
	input  wire logic [7:0]          mem_rdata_i
);
	import mlx_pkg::*;

	// ==========================================================
	// State
	logic [7:0]  rf [`MLX_RF_DEPTH];
	mlx_state_e  state;
	mlx_state_e  next_state;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic        rd_pend;
	logic        is_load;
	logic        is_dec;
	logic [3:0]  wreg;
	logic [3:0]  pair_hi;
	logic [7:0]  rdata;
	logic [15:0] pair_val;

	// ==========================================================
	// Decode
	wire [3:0]  f_reg     = byte2_i[7:4];
	wire [3:0]  f_pair    = byte2_i[3:0];
	wire [3:0]  p_hi      = {f_pair[3:1], 1'b0};
	wire [3:0]  p_lo      = {f_pair[3:1], 1'b1};
	wire [15:0] pair_addr = {rf[p_hi], rf[p_lo]};
	wire op_ind   = (opc_i == `MLX_OPC_LD_IND) ||
	                (opc_i == `MLX_OPC_ST_IND);
	wire op_short = (opc_i == `MLX_OPC_LD_SHORT) ||
	                (opc_i == `MLX_OPC_ST_SHORT);
	wire op_long  = (opc_i == `MLX_OPC_LD_LONG) ||
	                (opc_i == `MLX_OPC_ST_LONG);
	wire op_dec   = (opc_i == `MLX_OPC_LD_DEC);
	wire op_ld    = (opc_i == `MLX_OPC_LD_IND) ||
	                (opc_i == `MLX_OPC_LD_SHORT) ||
	                (opc_i == `MLX_OPC_LD_LONG) || op_dec;
	wire op_ok    = op_ind || op_short || op_long || op_dec;
	wire is_da    = op_long && (f_pair[3:1] == 3'b000);
	wire [15:0] long_off = {byte4_i, byte3_i};
	wire [15:0] short_off = {8'h00, byte3_i};
	wire [15:0] eff_addr =
		is_da    ? long_off :
		op_long  ? 16'(pair_addr + long_off) :
		op_short ? 16'(pair_addr + short_off) :
		pair_addr;
	// Parity of pair field picks the space; for direct forms 0000/0001 too
	wire space_data = f_pair[0];
	wire [3:0] cyc =
		op_long  ? `MLX_CYC_LONG :
		op_short ? `MLX_CYC_SHORT :
		op_dec   ? `MLX_CYC_DEC : `MLX_CYC_IND;
	wire block_st = !op_ld && !space_data && !PROG_WRITABLE;
	wire take     = start_i && (state == MLX_IDLE) && op_ok;
	wire last     = (state == MLX_RUN) && (cnt == 4'd0);
	wire [15:0] dec_val = 16'(pair_val - `MLX_DEC_ONE);

	// ==========================================================
	// Handshake outputs
	assign ready_o    = (state == MLX_IDLE);
	assign done_o     = last;
	assign flags_we_o = 1'b0;

	// ==========================================================
	// Next state
	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		unique case (state)
			MLX_IDLE:
			begin
				if (take)
				begin
					next_state = MLX_RUN;
					next_cnt   = 4'(cyc - 4'd2);
				end
			end
			MLX_RUN:
			begin
				if (cnt == 4'd0)
					next_state = MLX_IDLE;
				else
					next_cnt = 4'(cnt - 4'd1);
			end
		endcase
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state <= MLX_IDLE;
			cnt   <= 4'd0;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// ==========================================================
	// Memory request, one cycle after acceptance
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mem_req_o       <= 1'b0;
			mem_we_o        <= 1'b0;
			mem_space_o     <= MLX_SPACE_PROG;
			mem_addr_o      <= 16'h0000;
			mem_wdata_o     <= 8'h00;
			illegal_o       <= 1'b0;
			store_blocked_o <= 1'b0;
			rd_pend         <= 1'b0;
		end
		else
		begin
			mem_req_o       <= take && !block_st;
			illegal_o       <= start_i && (state == MLX_IDLE) && !op_ok;
			rd_pend         <= mem_req_o && !mem_we_o;
			if (take)
			begin
				mem_we_o        <= !op_ld && !block_st;
				mem_space_o     <= mlx_space_e'(space_data);
				mem_addr_o      <= eff_addr;
				mem_wdata_o     <= rf[f_reg];
				store_blocked_o <= block_st;
			end
		end
	end

	// ==========================================================
	// Instruction context and read capture
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			is_load  <= 1'b0;
			is_dec   <= 1'b0;
			wreg     <= 4'h0;
			pair_hi  <= 4'h0;
			pair_val <= 16'h0000;
			rdata    <= 8'h00;
		end
		else
		begin
			if (take)
			begin
				is_load  <= op_ld;
				is_dec   <= op_dec;
				wreg     <= f_reg;
				pair_hi  <= p_hi;
				pair_val <= pair_addr;
			end
			if (rd_pend)
				rdata <= mem_rdata_i;
		end
	end

	// ==========================================================
	// Working registers
	always_ff @(posedge clk_i)
	begin
		core_rdata_o <= srst_i ? 8'h00 : rf[core_addr_i];
		if (core_we_i)
			rf[core_addr_i] <= core_wdata_i;
		if (last && is_load)
			rf[wreg] <= rdata;
		if (last && is_dec)
		begin
			rf[pair_hi]        <= dec_val[15:8];
			rf[pair_hi | 4'h1] <= dec_val[7:0];
		end
	end

endmodule : mlx_exec

/* File: design/mlx_params.svh */
// Opcode and cycle-count constants for the memory transfer executor
`ifndef MLX_PARAMS_SVH
`define MLX_PARAMS_SVH

// ==========================================================
// Opcodes
`define MLX_OPC_LD_IND     8'hc3
`define MLX_OPC_ST_IND     8'hd3
`define MLX_OPC_LD_SHORT   8'he7
`define MLX_OPC_ST_SHORT   8'hf7
`define MLX_OPC_LD_LONG    8'ha7
`define MLX_OPC_ST_LONG    8'hb7
`define MLX_OPC_LD_DEC     8'he2

// ==========================================================
// Pair codes that select a direct address
`define MLX_PAIR_DA_PROG   4'h0
`define MLX_PAIR_DA_DATA   4'h1

// ==========================================================
// Cycle counts per form
`define MLX_CYC_IND        4'd10
`define MLX_CYC_SHORT      4'd12
`define MLX_CYC_LONG       4'd14
`define MLX_CYC_DEC        4'd10

// ==========================================================
// Misc
`define MLX_DEC_ONE        16'h0001
`define MLX_RF_DEPTH       16

`endif

/* File: design/mlx_pkg.sv */
// Types for the memory transfer executor
package mlx_pkg;

	typedef enum logic [0:0]
	{
		MLX_IDLE = 1'b0,
		MLX_RUN  = 1'b1
	} mlx_state_e;

	typedef enum logic [0:0]
	{
		MLX_SPACE_PROG = 1'b0,
		MLX_SPACE_DATA = 1'b1
	} mlx_space_e;

endpackage : mlx_pkg

/* File: testbench/mlx_exec_sva.sv */
// Assertions for the memory transfer executor
`timescale 1ns/1ns
// ====
// Checks
module mlx_exec_sva
(
	input logic			clk_i,
	input logic			srst_i,
	input logic			start_i,
	input logic [7:0]		opc_i,
	input logic [7:0]		byte2_i,
	input logic [7:0]		byte3_i,
	input logic [7:0]		byte4_i,
	input logic			ready_o,
	input logic			done_o,
	input logic			illegal_o,
	input logic			store_blocked_o,
	input logic			flags_we_o,
	input logic			mem_req_o,
	input logic			mem_we_o,
	input mlx_pkg::mlx_space_e	mem_space_o,
	input logic [15:0]		mem_addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	wire t = start_i && ready_o && opc_i inside
		{8'hc3, 8'hd3, 8'he7, 8'hf7, 8'ha7, 8'hb7, 8'he2};
	property p_ten; t && opc_i[2:0] != 3'h7 |=> !ready_o[*8] ##1 done_o;
	endproperty
	a_ten: assert property (p_ten) else $error("ten");
	property p_twl; t && opc_i[7:5] == 3'h7 && opc_i[2:0] == 3'h7 |=>
		!ready_o[*8] ##3 done_o; endproperty
	a_twl: assert property (p_twl) else $error("twelve");
	property p_ftn; t && opc_i[7:5] == 3'h5 |=> !ready_o[*8] ##5 done_o;
	endproperty
	a_ftn: assert property (p_ftn) else $error("fourteen");
	property p_flg; flags_we_o == 1'b0; endproperty
	a_flg: assert property (p_flg) else $error("flags");
	property p_sp; t |=> mem_space_o == $past(byte2_i[0]); endproperty
	a_sp: assert property (p_sp) else $error("space");
	property p_req; t |=> (mem_req_o == !store_blocked_o) ##1 !mem_req_o;
	endproperty
	a_req: assert property (p_req) else $error("access");
	property p_we; t |=>
		mem_we_o == ($past(opc_i[4]) && !store_blocked_o); endproperty
	a_we: assert property (p_we) else $error("direction");
	property p_da; t && opc_i[7:5] == 3'h5 && byte2_i[3:1] == 3'h0 |=>
		mem_addr_o == {$past(byte4_i), $past(byte3_i)}; endproperty
	a_da: assert property (p_da) else $error("direct");
	property p_blk; t |=> !store_blocked_o ||
		($past(opc_i[4]) && !$past(byte2_i[0])); endproperty
	a_blk: assert property (p_blk) else $error("blocked");
	wire u = start_i && ready_o && !t;
	property p_ill; u |=> illegal_o && ready_o; endproperty
	a_ill: assert property (p_ill) else $error("illegal");
	property p_ilq; !u |=> !illegal_o; endproperty
	a_ilq: assert property (p_ilq) else $error("quiet");
endmodule : mlx_exec_sva
bind mlx_exec mlx_exec_sva u_sva (.*);

/* File: testbench/mlx_exec_tb.sv */
// Bench for the memory transfer executor
`timescale 1ns/1ns
// ====
// Bench
module mlx_exec_tb;
	import mlx_pkg::*;
	logic		clk_i = 0, srst_i = 1, st = 0, we = 0;
	logic [7:0]	opc = 0, b2 = 0, b3 = 0, b4 = 0, wd = 0, rd, mwd, crd;
	logic [7:0]	ops [7] = '{8'hc3, 8'hd3, 8'he7, 8'hf7, 8'ha7, 8'hb7, 8'he2};
	logic [3:0]	ra = 0;
	logic		rdy, dn, req, mwe, fwe, ill, sb, sb2, req2;
	mlx_space_e	sp;
	logic [15:0]	ma;
	int		fails = 0, cmp_count = 0, seed = 32'h115d5926, rf [16];
	always #5 clk_i = ~clk_i;
	mlx_exec dut (.clk_i, .srst_i, .start_i(st), .opc_i(opc), .byte2_i(b2),
		.byte3_i(b3), .byte4_i(b4), .ready_o(rdy), .done_o(dn),
		.illegal_o(ill), .store_blocked_o(sb), .flags_we_o(fwe),
		.core_we_i(we), .core_addr_i(ra),
		.core_wdata_i(wd), .core_rdata_o(crd), .mem_req_o(req), .mem_we_o(mwe),
		.mem_space_o(sp), .mem_addr_o(ma), .mem_wdata_o(mwd), .mem_rdata_i(rd));
	mlx_mem mem (.clk_i, .req_i(req), .sp_i(sp), .addr_i(ma), .rdata_o(rd));
	mlx_exec #(.PROG_WRITABLE(1'b0)) dut_rom (.clk_i, .srst_i, .start_i(st),
		.opc_i(opc), .byte2_i(b2), .byte3_i(b3), .byte4_i(b4), .ready_o(),
		.done_o(), .illegal_o(), .store_blocked_o(sb2), .flags_we_o(),
		.core_we_i(we), .core_addr_i(ra), .core_wdata_i(wd), .core_rdata_o(),
		.mem_req_o(req2), .mem_we_o(), .mem_space_o(), .mem_addr_o(),
		.mem_wdata_o(), .mem_rdata_i(rd));
	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task results;
		$display("fails=%0d compares=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task dump;
		for (int i = 0; i < 17; i++)
		begin
			if (i > 0)
				chk(crd, rf[i - 1]);
			ra = 4'(i);
			@(negedge clk_i);
		end
	endtask : dump
	task run(input logic [7:0] o, input int p);
		int d, n, a, v, c;
		d = $random(seed) & 15;
		if (d / 2 == p / 2)
			d = d ^ 8;
		b2 = {4'(d), 4'(p)};
		b3 = $random(seed);
		b4 = $random(seed);
		n = o[7:4] == 4'ha || o[7:4] == 4'hb ? 14 : o[2:0] == 3'h7 ? 12 : 10;
		a = rf[p & 14] * 256 + rf[p | 1];
		if (n == 12)
			a = a + b3;
		if (n == 14)
			a = (p < 2 ? 0 : a) + b4 * 256 + b3;
		a = a & 65535;
		opc = o;
		st = 1;
		@(negedge clk_i);
		st = 0;
		chk(ma, a);
		chk(sp, p & 1);
		chk(req, 1);
		chk(mwe, o[4]);
		chk(sb, 0);
		chk(sb2, o[4] && !(p & 1));
		chk(req2, !(o[4] && !(p & 1)));
		if (o[4])
			chk(mwd, rf[d]);
		v = (a ^ a >> 8 ^ (p & 1) * 128) & 255;
		for (c = 1; dn !== 1'b1 && c < 20; c++)
			@(negedge clk_i);
		chk(c, n - 1);
		if (c == 20)
			results;
		if (!o[4])
			rf[d] = v;
		if (o == 8'he2)
		begin
			a = rf[p & 14] * 256 + rf[p | 1] + 65535;
			rf[p & 14] = a >> 8 & 255;
			rf[p | 1] = a & 255;
		end
		@(negedge clk_i);
		chk(rdy, 1);
		chk(fwe, 0);
		dump;
	endtask : run
	initial
	begin
		repeat (20) @(negedge clk_i);
		srst_i = 0;
		we = 1;
		for (int i = 0; i < 16; i++)
		begin
			ra = 4'(i);
			wd = $random(seed);
			rf[i] = wd;
			@(negedge clk_i);
		end
		we = 0;
		for (int j = 0; j < 35; j++)
			run(ops[j % 7], j < 14 ? j & 1 : $random(seed) & 15);
		opc = 8'h55;
		st = 1;
		@(negedge clk_i);
		st = 0;
		chk(ill, 1);
		chk(rdy, 1);
		@(negedge clk_i);
		chk(ill, 0);
		results;
	end
endmodule : mlx_exec_tb

/* File: testbench/mlx_mem.sv */
// Memory partner model
`timescale 1ns/1ns
// ====
// Read port
module mlx_mem
(
	input logic		clk_i,
	input logic		req_i,
	input logic		sp_i,
	input logic [15:0]	addr_i,
	output logic [7:0]	rdata_o
);
	initial rdata_o = 8'h00;
	always @(posedge clk_i)
		rdata_o <= req_i ? addr_i[7:0] ^ addr_i[15:8] ^ {sp_i, 7'h0}
			: ~rdata_o;
endmodule : mlx_mem
